// File: logic/pmt_io_decode.sv
// pmt_io_decode: trap mask register, fixed command ports and relocatable pm block
// assumes dword i/o cycles with byte enables, one request per cycle at most
`timescale 1ns/1ps
module pmt_io_decode
  import pmt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  output logic [15:0]      cfg_rdata,
  input  wire logic        command_ports_decode_enable,
  input  wire logic        pm_block_decode_enable,
  input  wire logic [15:0] pm_block_base,
  input  wire logic [63:0] trap_base_addresses,
  input  wire logic [3:0]  trap_forward_enables,
  input  wire logic        io_req,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  input  wire logic [3:0]  io_be,
  input  wire logic [31:0] io_wdata,
  output logic             io_claim,
  output logic             io_rd_valid,
  output logic [31:0]      io_rd_data,
  output logic             lpc_forward,
  output logic             system_mgmt_interrupt
);
  logic [15:0] trap_range_low_mask_q, trap_range_low_mask_d;
  logic [15:0] cfg_rdata_q, cfg_rdata_d;
  logic [7:0]  pm_command_port_q, pm_command_port_d;
  logic [7:0]  pm_scratch_port_q, pm_scratch_port_d;
  logic [3:0]  mon_sts_q, mon_sts_d;
  logic [15:0] addr_trk_q, addr_trk_d;
  logic [7:0]  cyc_trk_q, cyc_trk_d;
  logic        claim_q, claim_d;
  logic        rd_valid_q, rd_valid_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic        fwd_q, fwd_d;
  logic        smi_q, smi_d;
  logic [7:0]  pm_mem_q [0:PMT_MEM_BYTES-1];
  logic [3:0]  mem_we;
  logic [6:0]  mem_off [0:3];
  logic [3:0]  mon_hit;
  logic [3:0]  mon_en;
  logic        in_block;
  logic        in_ports;
  logic        trap_smi;
  logic        cmd_smi;

  // 32h-33h stay reserved, so the two interrupt registers are listed apart
  function automatic logic byte_writable(input logic [6:0] off);
    return (off < PMT_OFF_TMR) || (off >= PMT_OFF_CPU && off < PMT_OFF_LVL2)
           || (off == PMT_OFF_MOB) || (off == PMT_OFF_SPEED)
           || (off >= PMT_OFF_GPE0_STS && off < PMT_OFF_SMI_CTL + 7'h02)
           || (off >= PMT_OFF_SMI_STS && off < PMT_OFF_SMI_STS + 7'h02)
           || (off >= PMT_OFF_DEV_STS && off < PMT_OFF_DEV_STS + 7'h02)
           || (off >= PMT_OFF_TRAP_EN && off < PMT_OFF_TRAP_EN + 7'h02);
  endfunction : byte_writable

  function automatic logic [7:0] byte_read(input logic [6:0] off, input logic [7:0] mem,
                                           input logic [3:0] msts, input logic [15:0] atrk,
                                           input logic [7:0] ctrk);
    logic [7:0] r;
    r = PMT_BYTE_ZERO;
    if (off == PMT_OFF_MON_STS) begin
      r[PMT_MON_STS_LSB +: PMT_NMON] = msts;
    end else if (off == PMT_OFF_ADDR_TRK) begin
      r = atrk[7:0];
    end else if (off == PMT_OFF_ADDR_TRK + 7'h01) begin
      r = atrk[15:8];
    end else if (off == PMT_OFF_CYC_TRK) begin
      r = ctrk;
    end else if (off != PMT_OFF_SPEED && byte_writable(off)) begin
      r = mem;
    end
    return r;
  endfunction : byte_read

  genvar g;
  generate
    for (g = 0; g < PMT_NMON; g++) begin : g_mon
      pmt_trap_match u_match (
        .base     (trap_base_addresses[16*g +: 16]),
        .low_mask (trap_range_low_mask_q[PMT_MASK_W*g +: PMT_MASK_W]),
        .addr     (io_addr),
        .valid    (io_req),
        .hit      (mon_hit[g])
      );
    end
  endgenerate

  always_comb begin
    in_block = pm_block_decode_enable && io_req
               && (io_addr[15:PMT_BLK_AW] == pm_block_base[15:PMT_BLK_AW])
               && ({io_addr[PMT_BLK_AW-1:2], 2'b00} < PMT_OFF_HEALTH);
    in_ports = command_ports_decode_enable && io_req
               && (io_addr[15:2] == PMT_CMD_PORT_ADDR[15:2])
               && (io_be[PMT_CMD_PORT_ADDR[1:0]] || io_be[PMT_SCR_PORT_ADDR[1:0]]);
    mon_en   = pm_mem_q[PMT_OFF_TRAP_EN][PMT_TRAP_EN_LSB +: PMT_NMON];
    trap_smi = |(mon_hit & mon_en);
    cmd_smi  = in_ports && io_write && io_be[PMT_CMD_PORT_ADDR[1:0]]
               && pm_mem_q[PMT_OFF_SMI_CTL][PMT_CMD_IE_BIT];
    for (int i = 0; i < 4; i++) begin
      mem_off[i] = {io_addr[PMT_BLK_AW-1:2], 2'(i)};
      mem_we[i]  = in_block && io_write && io_be[i] && byte_writable(mem_off[i]);
    end
  end

  always_comb begin
    trap_range_low_mask_d = trap_range_low_mask_q;
    cfg_rdata_d           = cfg_rdata_q;
    if (cfg_wr && cfg_addr == PMT_CFG_MASK_OFF) begin
      trap_range_low_mask_d = cfg_wdata;
    end
    if (cfg_rd) begin
      cfg_rdata_d = (cfg_addr == PMT_CFG_MASK_OFF) ? trap_range_low_mask_q : 16'h0000;
    end
  end

  always_comb begin
    pm_command_port_d = pm_command_port_q;
    pm_scratch_port_d = pm_scratch_port_q;
    mon_sts_d         = mon_sts_q;
    addr_trk_d        = addr_trk_q;
    cyc_trk_d         = cyc_trk_q;
    claim_d           = in_block || in_ports;
    rd_valid_d        = (in_block || in_ports) && !io_write;
    rd_data_d         = PMT_WORD_ZERO;
    fwd_d             = |(mon_hit & trap_forward_enables);
    smi_d             = trap_smi || cmd_smi;
    if (in_ports && io_write && io_be[PMT_CMD_PORT_ADDR[1:0]]) begin
      pm_command_port_d = io_wdata[8*PMT_CMD_PORT_ADDR[1:0] +: 8];
    end
    if (in_ports && io_write && io_be[PMT_SCR_PORT_ADDR[1:0]]) begin
      pm_scratch_port_d = io_wdata[8*PMT_SCR_PORT_ADDR[1:0] +: 8];
    end
    if (in_ports && !io_write) begin
      if (io_be[PMT_CMD_PORT_ADDR[1:0]]) begin
        rd_data_d[8*PMT_CMD_PORT_ADDR[1:0] +: 8] = pm_command_port_q;
      end
      if (io_be[PMT_SCR_PORT_ADDR[1:0]]) begin
        rd_data_d[8*PMT_SCR_PORT_ADDR[1:0] +: 8] = pm_scratch_port_q;
      end
    end
    if (in_block && !io_write) begin
      for (int i = 0; i < 4; i++) begin
        if (io_be[i]) begin
          rd_data_d[8*i +: 8] = byte_read(mem_off[i], pm_mem_q[mem_off[i]], mon_sts_q,
                                          addr_trk_q, cyc_trk_q);
        end
      end
    end
    // write-one clears monitor status; a hit in the same cycle wins
    if (in_block && io_write && io_addr[PMT_BLK_AW-1:2] == PMT_OFF_MON_STS[PMT_BLK_AW-1:2]
        && io_be[0]) begin
      mon_sts_d = mon_sts_d & ~io_wdata[PMT_MON_STS_LSB +: PMT_NMON];
    end
    mon_sts_d = mon_sts_d | (mon_hit & mon_en);
    if (trap_smi) begin
      addr_trk_d = io_addr;
      cyc_trk_d  = {3'b000, io_be, io_write};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      trap_range_low_mask_q <= PMT_MASK_RESET;
      cfg_rdata_q           <= 16'h0000;
      pm_command_port_q     <= PMT_PORT_RESET;
      pm_scratch_port_q     <= PMT_PORT_RESET;
      mon_sts_q             <= 4'h0;
      addr_trk_q            <= 16'h0000;
      cyc_trk_q             <= 8'h00;
      claim_q               <= 1'b0;
      rd_valid_q            <= 1'b0;
      rd_data_q             <= PMT_WORD_ZERO;
      fwd_q                 <= 1'b0;
      smi_q                 <= 1'b0;
    end else begin
      trap_range_low_mask_q <= trap_range_low_mask_d;
      cfg_rdata_q           <= cfg_rdata_d;
      pm_command_port_q     <= pm_command_port_d;
      pm_scratch_port_q     <= pm_scratch_port_d;
      mon_sts_q             <= mon_sts_d;
      addr_trk_q            <= addr_trk_d;
      cyc_trk_q             <= cyc_trk_d;
      claim_q               <= claim_d;
      rd_valid_q            <= rd_valid_d;
      rd_data_q             <= rd_data_d;
      fwd_q                 <= fwd_d;
      smi_q                 <= smi_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int j = 0; j < PMT_MEM_BYTES; j++) begin
        pm_mem_q[j] <= PMT_BYTE_ZERO;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (mem_we[i]) begin
          pm_mem_q[mem_off[i]] <= io_wdata[8*i +: 8];
        end
      end
    end
  end

  assign cfg_rdata             = cfg_rdata_q;
  assign io_claim              = claim_q;
  assign io_rd_valid           = rd_valid_q;
  assign io_rd_data            = rd_data_q;
  assign lpc_forward           = fwd_q;
  assign system_mgmt_interrupt = smi_q;

  property p_trap_smi;
    @(posedge clk_sys) disable iff (!rst_b)
      (io_req && |(mon_hit & mon_en)) |=> system_mgmt_interrupt;
  endproperty
  a_trap_smi: assert property (p_trap_smi) else $error("trap hit gave no interrupt");

  property p_smi_cause;
    @(posedge clk_sys) disable iff (!rst_b)
      system_mgmt_interrupt |-> $past(trap_smi) || $past(cmd_smi);
  endproperty
  a_smi_cause: assert property (p_smi_cause) else $error("interrupt without cause");

  property p_fwd_only_enabled;
    @(posedge clk_sys) disable iff (!rst_b)
      lpc_forward |-> $past(|(mon_hit & trap_forward_enables));
  endproperty
  a_fwd_only_enabled: assert property (p_fwd_only_enabled)
    else $error("forward without enabled hit");

  property p_mask_window;
    @(posedge clk_sys) disable iff (!rst_b)
      (io_req && trap_range_low_mask_q[3:0] == 4'h3
       && io_addr[15:2] == trap_base_addresses[15:2]) |-> mon_hit[0];
  endproperty
  a_mask_window: assert property (p_mask_window) else $error("masked address missed");

  property p_upper_exact;
    @(posedge clk_sys) disable iff (!rst_b)
      mon_hit[0] |-> io_addr[15:4] == trap_base_addresses[15:4];
  endproperty
  a_upper_exact: assert property (p_upper_exact) else $error("upper bits not exact");

  property p_ports_gated;
    @(posedge clk_sys) disable iff (!rst_b)
      (io_req && !command_ports_decode_enable && !in_block) |=> !io_claim;
  endproperty
  a_ports_gated: assert property (p_ports_gated) else $error("port claimed while off");

  property p_cmd_store;
    @(posedge clk_sys) disable iff (!rst_b)
      (in_ports && io_write && io_be[2]) |=> pm_command_port_q == $past(io_wdata[23:16]);
  endproperty
  a_cmd_store: assert property (p_cmd_store) else $error("command byte not stored");

  property p_scratch_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !(in_ports && io_write && io_be[3]) |=> $stable(pm_scratch_port_q);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed");

  property p_health_free;
    @(posedge clk_sys) disable iff (!rst_b)
      (io_req && !in_ports && io_addr[6:0] >= PMT_OFF_HEALTH) |=> !io_claim;
  endproperty
  a_health_free: assert property (p_health_free) else $error("health range claimed");

  c_trap: cover property (@(posedge clk_sys) disable iff (!rst_b) system_mgmt_interrupt ##1
                          lpc_forward);
  c_cmd:  cover property (@(posedge clk_sys) disable iff (!rst_b) cmd_smi);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_b) io_rd_valid && in_block);
endmodule : pmt_io_decode

// File: shared/pmt_pkg.sv
// pmt_pkg: constants for the power-management trap and command port block
// assumes one core clock domain and a byte-addressed 16-bit i/o space
package pmt_pkg;
  localparam int          PMT_NMON          = 4;
  localparam int          PMT_MASK_W        = 4;
  localparam int          PMT_FIRST_MON     = 4;
  localparam logic [7:0]  PMT_CFG_MASK_OFF  = 8'hcc;
  localparam logic [15:0] PMT_MASK_RESET    = 16'h0000;
  localparam logic [15:0] PMT_CMD_PORT_ADDR = 16'h00b2;
  localparam logic [15:0] PMT_SCR_PORT_ADDR = 16'h00b3;
  localparam logic [7:0]  PMT_PORT_RESET    = 8'h00;
  localparam int          PMT_BLK_BYTES     = 128;
  localparam int          PMT_BLK_AW        = 7;
  localparam logic [6:0]  PMT_OFF_STS       = 7'h00;
  localparam logic [6:0]  PMT_OFF_EN        = 7'h02;
  localparam logic [6:0]  PMT_OFF_CTL       = 7'h04;
  localparam logic [6:0]  PMT_OFF_TMR       = 7'h08;
  localparam logic [6:0]  PMT_OFF_CPU       = 7'h10;
  localparam logic [6:0]  PMT_OFF_LVL2      = 7'h14;
  localparam logic [6:0]  PMT_OFF_LVL3      = 7'h15;
  localparam logic [6:0]  PMT_OFF_MOB       = 7'h20;
  localparam logic [6:0]  PMT_OFF_GPE0_STS  = 7'h28;
  localparam logic [6:0]  PMT_OFF_GPE0_EN   = 7'h2a;
  localparam logic [6:0]  PMT_OFF_GPE1_STS  = 7'h2c;
  localparam logic [6:0]  PMT_OFF_GPE1_EN   = 7'h2e;
  localparam logic [6:0]  PMT_OFF_SMI_CTL   = 7'h30;
  localparam logic [6:0]  PMT_OFF_SMI_STS   = 7'h34;
  localparam logic [6:0]  PMT_OFF_MON_STS   = 7'h40;
  localparam logic [6:0]  PMT_OFF_DEV_STS   = 7'h44;
  localparam logic [6:0]  PMT_OFF_TRAP_EN   = 7'h48;
  localparam logic [6:0]  PMT_OFF_ADDR_TRK  = 7'h4c;
  localparam logic [6:0]  PMT_OFF_CYC_TRK   = 7'h4e;
  localparam logic [6:0]  PMT_OFF_SPEED     = 7'h50;
  localparam logic [6:0]  PMT_OFF_HEALTH    = 7'h60;
  localparam int          PMT_MEM_BYTES     = 96;
  localparam int          PMT_CMD_IE_BIT    = 5;
  localparam int          PMT_TRAP_EN_LSB   = 4;
  localparam int          PMT_MON_STS_LSB   = 4;
  localparam logic [7:0]  PMT_BYTE_ZERO     = 8'h00;
  localparam logic [31:0] PMT_WORD_ZERO     = 32'h0000_0000;
endpackage : pmt_pkg

// File: logic/pmt_trap_match.sv
// pmt_trap_match: address range compare for one i/o trap monitor
// assumes the address is presented in the same cycle as its valid
`timescale 1ns/1ps
module pmt_trap_match
  import pmt_pkg::*;
(
  input  wire logic [15:0]         base,
  input  wire logic [PMT_MASK_W-1:0] low_mask,
  input  wire logic [15:0]         addr,
  input  wire logic                valid,
  output logic                     hit
);
  logic [15:0] diff;
  logic [15:0] care;

  always_comb begin
    diff = base ^ addr;
    care = {{(16-PMT_MASK_W){1'b1}}, ~low_mask};
    hit  = valid && ((diff & care) == 16'h0000);
  end
endmodule : pmt_trap_match

// File: testbench/pmt_host_model.sv
// pmt_host_model: host side issuing config and i/o cycles, one strobe cycle each
// assumes callers run off clk_sys; every change lands on the falling edge
`timescale 1ns/1ps
module pmt_host_model (
  input  wire logic        clk_sys,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_addr,
  output logic [15:0]      cfg_wdata,
  output logic             io_req,
  output logic             io_write,
  output logic [15:0]      io_addr,
  output logic [3:0]       io_be,
  output logic [31:0]      io_wdata
);
  initial begin
    {cfg_wr, cfg_rd, io_req, io_write} = 4'h0;
    {cfg_addr, cfg_wdata, io_addr, io_be, io_wdata} = 76'h0;
  end

  task automatic cfg_cycle(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, ~w, a, d};
    @(negedge clk_sys);
    // strobes drop; address and data show the inverse of their last value
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
  endtask : cfg_cycle

  task automatic io_cycle(input logic w, input logic [15:0] a, input logic [3:0] be,
                          input logic [31:0] d);
    @(negedge clk_sys);
    {io_req, io_write, io_addr, io_be, io_wdata} = {1'b1, w, a, be, d};
    @(negedge clk_sys);
    {io_req, io_write, io_addr, io_be, io_wdata} = {1'b0, ~w, ~a, ~be, ~d};
  endtask : io_cycle
endmodule : pmt_host_model

// File: testbench/pmt_io_decode_test.sv
// pmt_io_decode_test: self-checking bench for the trap mask, command ports and pm block
// assumes the host model drives requests; outputs are compared from a queue of notes
`timescale 1ns/1ps
module pmt_io_decode_test;
  import pmt_pkg::*;
  logic        clk_sys, rst_b, cfg_wr, cfg_rd, io_req, io_write, io_claim, io_rd_valid;
  logic        lpc_forward, system_mgmt_interrupt, cmd_en, blk_en, pend;
  logic [7:0]  cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, blk_base, io_addr, tmask;
  logic [15:0] tbase [4];
  logic [15:0] offs [8];
  logic [3:0]  io_be, fwd_en, ten;
  logic [31:0] io_wdata, io_rd_data, seed, r;
  logic [35:0] expq [$];
  logic [35:0] e;
  logic [35:0] outs;
  int          n_fail, checks_done;
  localparam logic [15:0] B = 16'h0580;

  pmt_host_model i_host (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .io_req(io_req), .io_write(io_write),
    .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata));

  pmt_io_decode i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .command_ports_decode_enable(cmd_en), .pm_block_decode_enable(blk_en),
    .pm_block_base(blk_base), .trap_base_addresses({tbase[3], tbase[2], tbase[1], tbase[0]}),
    .trap_forward_enables(fwd_en), .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
    .io_be(io_be), .io_wdata(io_wdata), .io_claim(io_claim), .io_rd_valid(io_rd_valid),
    .io_rd_data(io_rd_data), .lpc_forward(lpc_forward),
    .system_mgmt_interrupt(system_mgmt_interrupt));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] ex);
    checks_done++;
    if (seen !== ex) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic cfg(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] ex);
    i_host.cfg_cycle(w, a, d);
    if (!w) chk("cfg_rdata", {20'h0, cfg_rdata}, {20'h0, ex});
  endtask : cfg

  // notes claim, read answer and the trap outcome worked out from the bench's own copies
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
                    input logic [31:0] d, input logic cl, input logic [31:0] rd,
                    input logic cs);
    logic [3:0] hit;
    for (int m = 0; m < PMT_NMON; m++)
      hit[m] = ((a ^ tbase[m]) & ~{12'h000, tmask[m*4 +: 4]}) == 16'h0000;
    expq.push_back({cl, cl & ~w, (cl & ~w) ? rd : 32'h0, |(hit & fwd_en), |(hit & ten) | cs});
    i_host.io_cycle(w, a, be, d);
  endtask : io

  assign outs = {io_claim, io_rd_valid, io_rd_data, lpc_forward, system_mgmt_interrupt};

  always @(posedge clk_sys) pend <= io_req;

  always @(negedge clk_sys) begin
    if (rst_b && pend) begin
      e = (expq.size() > 0) ? expq.pop_front() : 36'h0;
      chk("io_out", outs, e);
    end else if (rst_b) begin
      chk("idle_out", outs, 36'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end

  initial begin
    {rst_b, n_fail, checks_done, seed, tmask, ten} = {1'b0, 64'h0, 32'd73721, 20'h0};
    {cmd_en, blk_en, blk_base, fwd_en} = {2'b11, B | 16'h0005, 4'b0101};
    tbase = '{16'h1230, 16'h2200, 16'h3300, 16'h4400};
    offs = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0008, 16'h000f, 16'h0010, 16'h1000};
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    cfg(0, PMT_CFG_MASK_OFF, 16'h0, 16'h0000);
    io(0, B | 16'h0028, 4'hf, 0, 1, 32'h0, 0);
    io(0, B | 16'h0034, 4'h3, 0, 1, 32'h0, 0);
    io(0, 16'h00b0, 4'hc, 0, 1, 32'h0, 0);
    $display("test reset values done");
    r = xs();
    cfg(1, PMT_CFG_MASK_OFF, r[15:0], 16'h0);
    cfg(0, PMT_CFG_MASK_OFF, 16'h0, r[15:0]);
    cfg(1, 8'hc0, ~r[15:0], 16'h0);
    cfg(0, 8'hc0, 16'h0, 16'h0000);
    cfg(0, PMT_CFG_MASK_OFF, 16'h0, r[15:0]);
    tmask = 16'h8f03;
    cfg(1, PMT_CFG_MASK_OFF, tmask, 16'h0);
    io(1, B | 16'h0048, 4'h1, 32'h0000_00f0, 1, 32'h0, 0);
    ten = 4'hf;
    foreach (tbase[m])
      foreach (offs[k])
        io(0, tbase[m] + offs[k], 4'h1, 0, 0, 32'h0, 0);
    io(1, B | 16'h0048, 4'h1, 32'h0, 1, 32'h0, 0);
    ten = 4'h0;
    io(1, tbase[2] + 16'h0005, 4'h1, 32'h0, 0, 32'h0, 0);
    io(0, B | 16'h0040, 4'h1, 0, 1, 32'h0000_00f0, 0);
    io(0, B | 16'h004c, 4'h7, 0, 1, 32'h0002_4408, 0);
    io(1, B | 16'h0040, 4'h1, 32'h0000_00f0, 1, 32'h0, 0);
    io(0, B | 16'h0040, 4'h1, 0, 1, 32'h0, 0);
    $display("test traps done");
    r = xs();
    io(1, B | 16'h0028, 4'hf, r, 1, 32'h0, 0);
    io(0, B | 16'h0028, 4'hf, 0, 1, r, 0);
    io(1, B | 16'h002c, 4'hf, ~r, 1, 32'h0, 0);
    io(0, B | 16'h002c, 4'hf, 0, 1, ~r, 0);
    io(1, B | 16'h0034, 4'h3, r, 1, 32'h0, 0);
    io(0, B | 16'h0034, 4'hf, 0, 1, {16'h0, r[15:0]}, 0);
    io(1, B | 16'h000c, 4'hf, 32'hffff_ffff, 1, 32'h0, 0);
    io(0, B | 16'h000c, 4'hf, 0, 1, 32'h0, 0);
    io(0, B | 16'h0038, 4'hf, 0, 1, 32'h0, 0);
    io(0, B | 16'h0060, 4'hf, 0, 0, 32'h0, 0);
    io(0, B | 16'h007c, 4'hf, 0, 0, 32'h0, 0);
    blk_en = 1'b0;
    io(0, B | 16'h0028, 4'hf, 0, 0, 32'h0, 0);
    blk_en = 1'b1;
    $display("test pm block done");
    io(1, B | 16'h0030, 4'hf, 32'hffff_0020, 1, 32'h0, 0);
    io(0, B | 16'h0030, 4'hf, 0, 1, 32'h0000_0020, 0);
    io(1, 16'h00b2, 4'h4, {8'h0, r[7:0], 16'h0}, 1, 32'h0, 1);
    io(1, 16'h00b3, 4'h8, {r[15:8], 24'h0}, 1, 32'h0, 0);
    io(1, B | 16'h0030, 4'h1, 32'h0, 1, 32'h0, 0);
    io(1, 16'h00b2, 4'h4, {8'h0, ~r[7:0], 16'h0}, 1, 32'h0, 0);
    io(0, 16'h00b0, 4'hc, 0, 1, {r[15:8], ~r[7:0], 16'h0}, 0);
    cmd_en = 1'b0;
    io(1, 16'h00b2, 4'h4, 32'h0, 0, 32'h0, 0);
    io(0, 16'h00b0, 4'hc, 0, 0, 32'h0, 0);
    $display("test command ports done");
    repeat (3) @(negedge clk_sys);
    give_verdict();
  end
endmodule : pmt_io_decode_test
